// >>> inc/tmr_pkg.sv
// shared constants and types for the 8-bit timer/counter with compare
package tmr_pkg;

  // ----------------------------------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] TMR_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] TMR_OFF_CNT = 32'h0000_0004;
  localparam logic [31:0] TMR_OFF_CMP = 32'h0000_0008;
  localparam logic [31:0] TMR_OFF_FLAG = 32'h0000_000c;
  localparam logic [31:0] TMR_OFF_MASK = 32'h0000_0010;
  localparam logic [31:0] TMR_OFF_ASYNC = 32'h0000_0014;
  localparam logic [31:0] TMR_OFF_PORT = 32'h0000_0018;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TMR_FLAG_OVF_BIT = 0;
  localparam int TMR_FLAG_CMP_BIT = 1;
  localparam int TMR_ASYNC_SEL_BIT = 0;
  localparam int TMR_PORT_DATA_BIT = 1 - 1;
  localparam int TMR_PORT_DIR_BIT = 1;

  // ----------------------------------------------------------------
  // modes, actions and clock selections
  // ----------------------------------------------------------------
  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PC_PWM = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC = 2'h2;
  localparam logic [1:0] TMR_WGM_FAST_PWM = 2'h3;
  localparam logic [1:0] TMR_COM_NONE = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;
  localparam logic [2:0] TMR_CS_STOP = 3'h0;
  localparam logic [2:0] TMR_CS_DIRECT = 3'h1;

  // prescaler tap masks for selections 2..7 (divide by 8..1024)
  localparam logic [9:0] TMR_DIV_MASK_2 = 10'h007;
  localparam logic [9:0] TMR_DIV_MASK_3 = 10'h01f;
  localparam logic [9:0] TMR_DIV_MASK_4 = 10'h03f;
  localparam logic [9:0] TMR_DIV_MASK_5 = 10'h07f;
  localparam logic [9:0] TMR_DIV_MASK_6 = 10'h0ff;
  localparam logic [9:0] TMR_DIV_MASK_7 = 10'h3ff;

  // ----------------------------------------------------------------
  // counter limits, bus codes, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_ONE = 8'h01;
  localparam logic [1:0] TMR_HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] TMR_CNT_RST = 8'h00;
  localparam logic [7:0] TMR_CMP_RST = 8'h00;

  typedef struct packed {
    logic force_cmp;
    logic [1:0] com;
    logic [1:0] wgm;
    logic [2:0] cs;
  } tmr_ctrl_t;

  typedef struct packed {
    logic cmp;
    logic ovf;
  } tmr_flags_t;

  localparam tmr_ctrl_t TMR_CTRL_RST = 8'h00;
  localparam tmr_flags_t TMR_FLAGS_RST = 2'h0;

endpackage

// >>> test/tb_timer8_counter_compare_core.sv
// self-checking bench for the timer core
`timescale 1ns/1ps
module tb_timer8_counter_compare_core;
  import tmr_pkg::*;
  localparam int XH = 170;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic ack_en = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, xin, pin_out, pin_oe, pin_lvl;
  logic ovf_irq, cmp_irq, ovf_ack, cmp_ack, at_top, at_bot;
  wire logic hready = hreadyout;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 89;
  int cyc = 0;
  int t_rd, t0, k, e;
  logic [7:0] v, cv;
  logic [7:0] tc [8] = '{8'he0, 8'hc0, 8'ha0, 8'h80, 8'h40, 8'h58, 8'hd8, 8'ha0};
  logic te [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] pc [4] = '{8'h00, 8'h00, 8'h00, 8'h60};
  logic [7:0] pp [4] = '{8'h01, 8'h03, 8'h02, 8'h03};
  logic pe [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  always #20 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  tmr_core dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .crystal_pin_in(xin), .crystal_pin_out(),
    .compare_pin_out(pin_out), .compare_pin_oe(pin_oe), .overflow_irq(ovf_irq),
    .compare_irq(cmp_irq), .overflow_irq_ack(ovf_ack), .compare_irq_ack(cmp_ack),
    .counter_at_top(at_top), .counter_at_bottom(at_bot)
  );
  tmr_partner #(.XH(XH)) ptn_u (
    .hclk(hclk), .hresetn(hresetn), .ack_en(ack_en), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
    .ovf_ack(ovf_ack), .cmp_ack(cmp_ack), .xin(xin), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_lvl(pin_lvl)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy(output logic [31:0] d);
    @(negedge hclk);
    while (hready !== 1'b1) @(negedge hclk);
    d = hrdata;
    t_rd = cyc;
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= TMR_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task automatic blk(input logic [7:0] c, input logic [31:0] x);
    bus(1'b1, TMR_OFF_CNT, 32'(c));
    bus(1'b1, TMR_OFF_CTRL, 32'h01);
    repeat (10) @(posedge hclk);
    bus(1'b1, TMR_OFF_CTRL, 32'h00);
    bus(1'b0, TMR_OFF_FLAG, 32'h0);
    check(rd, x);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check(at_bot, 32'h1);
    bus(1'b1, 32'h1c, 32'hff);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 32'(4 * i), 32'h0);
      check(rd, 32'h0);
    end
    $display("test reset done");
    v = 8'($random(seed));
    bus(1'b1, TMR_OFF_CNT, 32'hff);
    @(negedge hclk);
    check(at_top, 32'h1);
    bus(1'b1, TMR_OFF_CNT, 32'(v));
    repeat (20) @(posedge hclk);
    bus(1'b0, TMR_OFF_CNT, 32'h0);
    check(rd, 32'(v));
    $display("test stop done");
    bus(1'b1, TMR_OFF_MASK, 32'h3);
    bus(1'b1, TMR_OFF_CNT, 32'hf0);
    bus(1'b1, TMR_OFF_CTRL, 32'h01);
    bus(1'b0, TMR_OFF_CNT, 32'h0);
    v = rd[7:0];
    t0 = t_rd;
    repeat (6) begin
      k = $random(seed) & 63;
      repeat (k) @(posedge hclk);
      bus(1'b0, TMR_OFF_CNT, 32'h0);
      check(rd, 32'(8'(v + t_rd - t0)));
    end
    bus(1'b1, TMR_OFF_CTRL, 32'h00);
    bus(1'b0, TMR_OFF_FLAG, 32'h0);
    check(rd, 32'h3);
    check({ovf_irq, cmp_irq}, 32'h3);
    ack_en <= 1'b1;
    k = 0;
    while ((ovf_irq | cmp_irq) !== 1'b0 && k < 50) begin
      @(negedge hclk);
      k++;
    end
    bus(1'b0, TMR_OFF_FLAG, 32'h0);
    check(rd, 32'h0);
    ack_en <= 1'b0;
    $display("test count done");
    bus(1'b1, TMR_OFF_CMP, 32'h40);
    blk(8'h40, 32'h0);
    blk(8'h3e, 32'h2);
    bus(1'b1, TMR_OFF_FLAG, 32'h3);
    bus(1'b0, TMR_OFF_FLAG, 32'h0);
    check(rd, 32'h0);
    $display("test match done");
    bus(1'b1, TMR_OFF_ASYNC, 32'h1);
    bus(1'b1, TMR_OFF_CNT, 32'h0);
    bus(1'b1, TMR_OFF_CTRL, 32'h01);
    repeat (200) @(posedge hclk);
    bus(1'b1, TMR_OFF_CTRL, 32'h00);
    bus(1'b0, TMR_OFF_CNT, 32'h0);
    cv = rd[7:0];
    e = 200 * 40 / (2 * XH);
    check(32'(cv + 3 >= e && cv <= e + 3), 32'h1);
    bus(1'b1, TMR_OFF_ASYNC, 32'h0);
    $display("test crystal done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, TMR_OFF_CTRL, 32'(tc[i]));
      @(negedge hclk);
      check(pin_out, 32'(te[i]));
    end
    bus(1'b0, TMR_OFF_FLAG, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, TMR_OFF_CNT, 32'h0);
    check(rd, 32'(cv));
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, TMR_OFF_CTRL, 32'(pc[i]));
      bus(1'b1, TMR_OFF_PORT, 32'(pp[i]));
      @(negedge hclk);
      check(pin_lvl, 32'(pe[i]));
    end
    $display("test output done");
    bus(1'b1, TMR_OFF_CTRL, 32'h18);
    v = 8'($random(seed));
    bus(1'b1, TMR_OFF_CMP, 32'(v));
    bus(1'b0, TMR_OFF_CMP, 32'h0);
    check(rd, 32'(v));
    bus(1'b1, TMR_OFF_CTRL, 32'h00);
    bus(1'b0, TMR_OFF_CMP, 32'h0);
    check(rd, 32'h40);
    $display("test buffer done");
    finish_test();
  end
endmodule

// >>> test/tmr_core_chk.sv
// assertion checker bound to the timer core ports
`timescale 1ns/1ps
module tmr_core_chk
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and status
  input wire logic compare_pin_out,
  input wire logic compare_pin_oe,
  input wire logic overflow_irq,
  input wire logic overflow_irq_ack,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic crystal_pin_in,
  input wire logic crystal_pin_out
);
  // ----------------------------------------------------------------
  // shadow of written control state
  // ----------------------------------------------------------------
  logic dp_wr;
  logic [31:0] dp_a;
  tmr_ctrl_t ctl;
  logic [1:0] msk;
  logic [1:0] prt;
  logic asy;
  wire take = hsel && hready && htrans == TMR_HTRANS_NONSEQ;
  wire wr = dp_wr && hready;
  wire run = ctl.wgm == TMR_WGM_NORMAL && ctl.cs == TMR_CS_DIRECT && !asy && !dp_wr;
  wire stop = ctl.cs == TMR_CS_STOP && !dp_wr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_a <= 32'h0;
      ctl <= TMR_CTRL_RST;
      msk <= 2'h0;
      prt <= 2'h0;
      asy <= 1'b0;
    end else begin
      if (hready) begin
        dp_wr <= take && hwrite;
        dp_a <= haddr;
      end
      if (wr && dp_a == TMR_OFF_CTRL) ctl <= hwdata[7:0];
      if (wr && dp_a == TMR_OFF_MASK) msk <= hwdata[1:0];
      if (wr && dp_a == TMR_OFF_PORT) prt <= hwdata[1:0];
      if (wr && dp_a == TMR_OFF_ASYNC) asy <= hwdata[TMR_ASYNC_SEL_BIT];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ends_apart: assert property (!(counter_at_top && counter_at_bottom))
    else $error("top and bottom together");
  a_wrap_bottom: assert property (run && $past(run) && counter_at_top |=> counter_at_bottom)
    else $error("no wrap to zero");
  a_count_up: assert property (run && $past(run) && counter_at_bottom |=> !counter_at_bottom)
    else $error("counter did not advance");
  a_ovf_set: assert property (run && $past(run) && counter_at_top && msk[0] |=> overflow_irq)
    else $error("overflow not raised");
  a_ovf_held: assert property (overflow_irq && !overflow_irq_ack && !dp_wr |=> overflow_irq)
    else $error("overflow cleared by hardware");
  a_stop_hold: assert property (stop && $past(stop) && $past(stop, 2) |=>
    $stable(counter_at_top) && $stable(counter_at_bottom)) else $error("stopped counter moved");
  a_pin_mux: assert property (ctl.com == TMR_COM_NONE |-> compare_pin_out == prt[0])
    else $error("port data not on pin");
  a_pin_dir: assert property (compare_pin_oe == prt[1])
    else $error("pin direction wrong");
  a_xtal_echo: assert property ($past(hresetn, 2) |->
    crystal_pin_out == !$past(crystal_pin_in, 2)) else $error("crystal echo wrong");
endmodule
bind tmr_core tmr_core_chk chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
  .overflow_irq(overflow_irq), .overflow_irq_ack(overflow_irq_ack),
  .counter_at_top(counter_at_top), .counter_at_bottom(counter_at_bottom),
  .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out)
);

// >>> test/tmr_partner.sv
// partner: crystal oscillator, interrupt service and pin pull-down
`timescale 1ns/1ps
module tmr_partner #(
  parameter int XH = 170,
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // interrupt service
  input wire logic ack_en,
  input wire logic ovf_irq,
  input wire logic cmp_irq,
  output logic ovf_ack,
  output logic cmp_ack,
  // pins
  output logic xin,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_lvl
);
  int wo;
  int wc;
  initial begin
    xin = 1'b0;
    #1;
    forever #(XH) xin = ~xin;
  end
  assign pin_lvl = pin_oe ? pin_out : 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wo <= 0;
      wc <= 0;
      ovf_ack <= 1'b0;
      cmp_ack <= 1'b0;
    end else begin
      ovf_ack <= wo == DLY;
      cmp_ack <= wc == DLY;
      wo <= (ack_en && ovf_irq && wo != DLY) ? wo + 1 : 0;
      wc <= (ack_en && cmp_irq && wc != DLY) ? wc + 1 : 0;
    end
  end
endmodule

// >>> verilog/tmr_core.sv
// 8-bit timer/counter with one compare channel behind an ahb-lite slave
//
// What this block does
// [R1] - tick from io clock, or crystal when selected
// [R2] - each tick clears, increments or decrements counter
// [R3] - clock select zero stops the counter
// [R4] - cpu counter access anytime; cpu write wins
// [R5] - waveform mode sets sequence and overflow condition
// [R6] - comparator match sets match flag next tick
// [R7] - enabled flag requests irq; ack or one clears
// [R8] - pwm modes double buffer compare at top/bottom
// [R9] - cpu compare access hits buffer or active register
// [R10] - force strobe acts like match, non-pwm only
// [R11] - counter write blocks match in next tick
// [R12] - compare output state survives mode changes
// [R13] - output action field unbuffered, acts next match
// [R14] - nonzero action field overrides port, direction separate
// [R15] - action field zero leaves compare output alone
// [R16] - action field: pwm polarity, or set/clear/toggle
// [R17] - normal mode counts up, wraps ff to 00
// [R18] - normal overflow set as counter becomes zero
// [R19] - overflow flag cleared by overflow irq ack
// [R20] - top and bottom indications from counter
// [R21] - software sets compare state before pin direction
// [R22] - software avoids writing counter equal to compare
// [R23] - maximum is ff, bottom is zero
// [R24] - everything resets to zero
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module tmr_core #(
  parameter int PRESCALE_W = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // crystal oscillator pins
  input wire logic crystal_pin_in,
  output logic crystal_pin_out,
  // compare output pin
  output logic compare_pin_out,
  output logic compare_pin_oe,
  // interrupt requests and acknowledges
  output logic overflow_irq,
  output logic compare_irq,
  input wire logic overflow_irq_ack,
  input wire logic compare_irq_ack,
  // counter status
  output logic counter_at_top,
  output logic counter_at_bottom
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tmr_ctrl_t timer_control_reg;
  tmr_flags_t timer_flag_reg;
  tmr_flags_t timer_mask_reg;
  logic [7:0] counter_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic async_clock_select;
  logic port_data;
  logic compare_pin_direction_bit;
  logic compare_output;
  logic count_down;
  logic block_pending;
  logic crystal_sync;
  logic crystal_prev;
  logic wr_pend;
  logic rd_wait;
  logic [31:0] addr_q;
  logic timer_tick;
  logic [7:0] next_counter;
  logic next_count_down;
  logic next_compare_output;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire addr_take = hsel && hready && (htrans == TMR_HTRANS_NONSEQ);
  wire wr_ctrl = wr_pend && (addr_q == TMR_OFF_CTRL);
  wire wr_cnt = wr_pend && (addr_q == TMR_OFF_CNT);
  wire wr_cmp = wr_pend && (addr_q == TMR_OFF_CMP);
  wire wr_flag = wr_pend && (addr_q == TMR_OFF_FLAG);
  wire wr_mask = wr_pend && (addr_q == TMR_OFF_MASK);
  wire wr_async = wr_pend && (addr_q == TMR_OFF_ASYNC);
  wire wr_port = wr_pend && (addr_q == TMR_OFF_PORT);
  wire tmr_ctrl_t wdata_ctrl = tmr_ctrl_t'(hwdata[7:0]);

  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [1:0] wgm = timer_control_reg.wgm;
  wire [1:0] com = timer_control_reg.com;
  wire is_pwm = (wgm == TMR_WGM_PC_PWM) || (wgm == TMR_WGM_FAST_PWM);
  wire at_max = (counter_value == TMR_MAX); // [R23]
  wire at_bottom = (counter_value == TMR_BOTTOM); // [R23]
  wire match = (counter_value == compare_value); // [R6]
  wire cmp_event = timer_tick && match && !block_pending; // [R6] [R11]
  wire [7:0] cnt_inc = counter_value + TMR_ONE;
  wire [7:0] cnt_dec = counter_value - TMR_ONE;
  wire force_hit = wr_ctrl && wdata_ctrl.force_cmp &&
                   (wdata_ctrl.wgm != TMR_WGM_PC_PWM) &&
                   (wdata_ctrl.wgm != TMR_WGM_FAST_PWM); // [R10]
  wire buf_load = timer_tick && is_pwm && at_max; // [R8]

  assign counter_at_top = at_max; // [R20]
  assign counter_at_bottom = at_bottom; // [R20]

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  tmr_sync #(
    .WIDTH(1)
  ) u_crystal_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(crystal_pin_in),
    .q(crystal_sync)
  );

  wire crystal_rise = crystal_sync && !crystal_prev;
  wire tick_src = async_clock_select ? crystal_rise : 1'b1; // [R1]

  tmr_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_en(tick_src),
    .cs(timer_control_reg.cs), // [R3]
    .tick(timer_tick)
  );

  // ----------------------------------------------------------------
  // counter sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_counter = counter_value;
    next_count_down = count_down;
    if (wr_cnt) begin
      next_counter = hwdata[7:0]; // [R4]
    end else if (timer_tick) begin
      case (wgm) // [R2] [R5]
        TMR_WGM_NORMAL, TMR_WGM_FAST_PWM: begin
          next_counter = cnt_inc; // [R17]
          next_count_down = 1'b0;
        end
        TMR_WGM_CTC: begin
          next_counter = match ? TMR_BOTTOM : cnt_inc;
          next_count_down = 1'b0;
        end
        TMR_WGM_PC_PWM: begin
          if (count_down && at_bottom) begin
            next_counter = cnt_inc;
            next_count_down = 1'b0;
          end else if (!count_down && at_max) begin
            next_counter = cnt_dec;
            next_count_down = 1'b1;
          end else begin
            next_counter = count_down ? cnt_dec : cnt_inc;
          end
        end
        default: next_counter = counter_value;
      endcase
    end
  end

  // overflow condition per mode
  wire ovf_set = timer_tick && !wr_cnt &&
                 (((wgm != TMR_WGM_PC_PWM) && at_max) || // [R18]
                  ((wgm == TMR_WGM_PC_PWM) && count_down &&
                   (counter_value == TMR_ONE))); // [R5]

  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  always_comb begin
    next_compare_output = compare_output; // [R12]
    if (force_hit || (cmp_event && !is_pwm)) begin
      case (force_hit ? wdata_ctrl.com : com) // [R10] [R13] [R16]
        TMR_COM_TOGGLE: next_compare_output = !compare_output;
        TMR_COM_CLEAR: next_compare_output = 1'b0;
        TMR_COM_SET: next_compare_output = 1'b1;
        default: next_compare_output = compare_output; // [R15]
      endcase
    end else if (timer_tick && (wgm == TMR_WGM_FAST_PWM)) begin
      if (cmp_event && (com == TMR_COM_TOGGLE)) begin
        next_compare_output = !compare_output;
      end else if (cmp_event && (com[1] == 1'b1)) begin
        next_compare_output = com[0];
      end else if (at_max && (com[1] == 1'b1)) begin
        next_compare_output = !com[0];
      end
    end else if (cmp_event && (wgm == TMR_WGM_PC_PWM) && (com[1] == 1'b1)) begin
      next_compare_output = count_down ? !com[0] : com[0];
    end
  end

  // port override; direction stays with the direction bit
  assign compare_pin_out = (com != TMR_COM_NONE) ? compare_output : port_data; // [R14]
  assign compare_pin_oe = compare_pin_direction_bit; // [R14]
  assign crystal_pin_out = !crystal_sync;

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  assign overflow_irq = timer_flag_reg.ovf && timer_mask_reg.ovf;
  assign compare_irq = timer_flag_reg.cmp && timer_mask_reg.cmp; // [R7]

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      TMR_OFF_CTRL: rd_mux[6:0] = timer_control_reg[6:0];
      TMR_OFF_CNT: rd_mux[7:0] = counter_value; // [R4]
      TMR_OFF_CMP: rd_mux[7:0] = is_pwm ? compare_buffer : compare_value; // [R9]
      TMR_OFF_FLAG: rd_mux[1:0] = timer_flag_reg;
      TMR_OFF_MASK: rd_mux[1:0] = timer_mask_reg;
      TMR_OFF_ASYNC: rd_mux[TMR_ASYNC_SEL_BIT] = async_clock_select;
      TMR_OFF_PORT: begin
        rd_mux[TMR_PORT_DATA_BIT] = port_data;
        rd_mux[TMR_PORT_DIR_BIT] = compare_pin_direction_bit;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus phase registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      addr_q <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_take && hwrite;
      rd_wait <= addr_take && !hwrite;
      if (addr_take) begin
        addr_q <= haddr;
      end
      if (rd_wait) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_reg <= TMR_CTRL_RST; // [R24]
      timer_mask_reg <= TMR_FLAGS_RST;
      async_clock_select <= 1'b0;
      port_data <= 1'b0;
      compare_pin_direction_bit <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_control_reg <= {1'b0, wdata_ctrl.com, wdata_ctrl.wgm, wdata_ctrl.cs}; // [R13]
      end
      if (wr_mask) begin
        timer_mask_reg <= tmr_flags_t'(hwdata[1:0]);
      end
      if (wr_async) begin
        async_clock_select <= hwdata[TMR_ASYNC_SEL_BIT]; // [R1]
      end
      if (wr_port) begin
        port_data <= hwdata[TMR_PORT_DATA_BIT];
        compare_pin_direction_bit <= hwdata[TMR_PORT_DIR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // counter, compare and output state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_value <= TMR_CNT_RST; // [R24]
      count_down <= 1'b0;
      compare_output <= 1'b0;
      crystal_prev <= 1'b0;
    end else begin
      counter_value <= next_counter;
      count_down <= next_count_down;
      compare_output <= next_compare_output;
      crystal_prev <= crystal_sync;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value <= TMR_CMP_RST;
      compare_buffer <= TMR_CMP_RST;
    end else begin
      if (wr_cmp) begin
        compare_buffer <= hwdata[7:0]; // [R9]
      end
      if (wr_cmp && !is_pwm) begin
        compare_value <= hwdata[7:0]; // [R8]
      end else if (buf_load) begin
        compare_value <= compare_buffer; // [R8]
      end
    end
  end

  // a counter write arms the block until the next tick consumes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_pending <= 1'b0;
    end else if (wr_cnt) begin
      block_pending <= 1'b1; // [R11]
    end else if (timer_tick) begin
      block_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set wins over any clear
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_flag_reg <= TMR_FLAGS_RST;
    end else begin
      timer_flag_reg.ovf <= ovf_set ||
        (timer_flag_reg.ovf && !overflow_irq_ack &&
         !(wr_flag && hwdata[TMR_FLAG_OVF_BIT])); // [R18] [R19]
      timer_flag_reg.cmp <= cmp_event ||
        (timer_flag_reg.cmp && !compare_irq_ack &&
         !(wr_flag && hwdata[TMR_FLAG_CMP_BIT])); // [R6] [R7]
    end
  end

endmodule

// >>> verilog/tmr_prescaler.sv
// clock select and prescaler producing the timer tick enable
`timescale 1ns/1ps
module tmr_prescaler #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // source and selection
  input wire logic src_en,
  input wire logic [2:0] cs,
  // tick
  output logic tick
);
  import tmr_pkg::*;

  logic [WIDTH-1:0] presc;
  logic [WIDTH-1:0] mask;
  wire running = (cs != TMR_CS_STOP);

  always_comb begin
    case (cs)
      3'h2: mask = WIDTH'(TMR_DIV_MASK_2);
      3'h3: mask = WIDTH'(TMR_DIV_MASK_3);
      3'h4: mask = WIDTH'(TMR_DIV_MASK_4);
      3'h5: mask = WIDTH'(TMR_DIV_MASK_5);
      3'h6: mask = WIDTH'(TMR_DIV_MASK_6);
      3'h7: mask = WIDTH'(TMR_DIV_MASK_7);
      default: mask = '0;
    endcase
  end

  // no source selected means no tick at all
  assign tick = running && src_en && ((presc & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= '0;
    end else if (!running) begin
      presc <= '0;
    end else if (src_en) begin
      presc <= presc + WIDTH'(1);
    end
  end

endmodule

// >>> verilog/tmr_sync.sv
// two-stage synchroniser for pins entering the bus clock domain
`timescale 1ns/1ps
module tmr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule
